// ---- timer_defs.svh ----
// Notes on behaviour
// - two 16-bit down counters, separately addressed
// - reload register refills counter past zero when periodic
// - tick source: 1, 5, 25, 50 us or external
// - user clock input takes regular or random pulses
// - gate input ignored unless gating enabled
// - run set on start, cleared stop/gate/reset
// - gate-enabled output follows mode bit 31
// - respond only when address bits 8-14 match jumpers
// - address bit 15 picks counter 0 or 1
// - control commands 60 64 65 66 67 6e 6f
// - read commands 20 id, 24 count, 25 mode
// - prepare loads one shared interrupt setup register
// - prepare bits 27-30 level, bit 31 allow
// - level 0 highest priority, level 3 lowest
// - prepare never busy; code 5 means not done
// - periodic: zero to minus one interrupts and reloads
// - mode bits 28-30 encode tick source
// - gate drop stops count, clears run, interrupts
// - device reset keeps count and reload registers
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH
`define CMD_PREPARE    8'h60
`define CMD_LOAD_VAL   8'h64
`define CMD_LOAD_MODE  8'h65
`define CMD_START_PER  8'h66
`define CMD_START_APER 8'h67
`define CMD_STOP       8'h6e
`define CMD_DEV_RESET  8'h6f
`define CMD_READ_ID    8'h20
`define CMD_READ_COUNT 8'h24
`define CMD_READ_MODE  8'h25
`define CC_OK          3'h7
`define CC_BUSY        3'h1
`define CC_DATA_CHECK  3'h5
`define PREP_LEVEL_LSB 1
`define PREP_ALLOW_BIT 0
`define MODE_SRC_LSB   1
`define MODE_GATE_BIT  0
`define CLK_HZ         10000000
`define TICK_1US_NS    1000
`define TICK_5US_NS    5000
`define TICK_25US_NS   25000
`define TICK_50US_NS   50000
`define NS_PER_S       1000000000
`define CYC_1US  ((`TICK_1US_NS  * (`CLK_HZ / 1000000)) / 1000)
`define CYC_5US  ((`TICK_5US_NS  * (`CLK_HZ / 1000000)) / 1000)
`define CYC_25US ((`TICK_25US_NS * (`CLK_HZ / 1000000)) / 1000)
`define CYC_50US ((`TICK_50US_NS * (`CLK_HZ / 1000000)) / 1000)
`define ID_WORD_RST    16'h5a01
`endif

// ---- timer_pkg.sv ----
package timer_pkg;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [6:0]  card;
    logic        sel;
    logic [15:0] data;
  } cmd_block_t;
  typedef struct packed {
    logic        gate_en;
    logic [2:0]  src;
  } mode_t;
  typedef struct packed {
    logic        allow;
    logic [3:0]  level;
  } setup_t;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARMED  = 2'b01,
    ST_COUNT  = 2'b11
  } run_state_t;
endpackage : timer_pkg

// ---- tick_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module tick_gen
  import timer_pkg::*;
(
  input  wire logic core_clk,  // system clock
  input  wire logic rst,       // async reset
  output logic [3:0] tick      // 1,5,25,50 us strobes
);
  localparam int unsigned PER [4] = '{`CYC_1US, `CYC_5US, `CYC_25US, `CYC_50US};
  logic [9:0] cnt_q [4];
  logic [9:0] cnt_d [4];
  logic [3:0] tick_d;
  genvar g;
  // ************************************************
  // one divider per internal rate
  // ************************************************
  generate
    for (g = 0; g < 4; g++) begin : g_div
      always_comb begin
        if (cnt_q[g] == 10'(PER[g] - 1)) begin
          cnt_d[g]  = 10'h000;
          tick_d[g] = 1'b1;
        end else begin
          cnt_d[g]  = cnt_q[g] + 10'h001;
          tick_d[g] = 1'b0;
        end
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          cnt_q[g] <= 10'h000;
          tick[g]  <= 1'b0;
        end else begin
          cnt_q[g] <= cnt_d[g];
          tick[g]  <= tick_d[g];
        end
      end
    end
  endgenerate
endmodule : tick_gen
`default_nettype wire

// ---- timer_attach.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module timer_attach
  import timer_pkg::*;
#(
  parameter logic [15:0] ID_WORD = `ID_WORD_RST  // arbitrary value
) (
  input  wire logic       core_clk,     // 10 MHz clock
  input  wire logic       rst,          // async reset, high
  input  wire logic       halt,         // channel halt pulse
  input  wire logic [6:0] card_addr,    // jumper address
  input  wire logic       cmd_valid,    // command block strobe
  input  wire cmd_block_t cmd_in,       // immediate_command_block
  input  wire logic       data_ok,      // channel parity good
  input  wire logic [1:0] user_clk,     // external ticks
  input  wire logic [1:0] user_gate,    // external gates
  output logic            rsp_valid,    // answer strobe
  output logic [2:0]      rsp_cc,       // condition code
  output logic [15:0]     rsp_data,     // read data
  output logic [1:0]      run,          // run lines
  output logic [1:0]      gate_en,      // gate enable lines
  output logic [1:0]      irq_req,      // pending per counter
  output logic [3:0]      irq_level,    // shared level
  output logic [3:0]      irq_level_oh  // one-hot, bit 0 highest
);
  logic [3:0]  tick;
  setup_t      setup_q, setup_d;
  logic        rsp_valid_d;
  logic [2:0]  rsp_cc_d;
  logic [15:0] rsp_data_d;
  logic [15:0] cnt_q [2];
  logic [15:0] cnt_d [2];
  logic [15:0] rld_q [2];
  logic [15:0] rld_d [2];
  mode_t       mode_q [2];
  mode_t       mode_d [2];
  run_state_t  st_q [2];
  run_state_t  st_d [2];
  logic [1:0]  per_q, per_d, pend_q, pend_d;
  logic [1:0]  uclk_q, gate_q, uclk_prev_q;
  logic        hit;
  tick_gen u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (tick)
  );
  assign hit = cmd_valid && (cmd_in.card == card_addr);
  // ************************************************
  // shared setup and command answers
  // ************************************************
  always_comb begin
    setup_d     = setup_q;
    rsp_valid_d = 1'b0;
    rsp_cc_d    = `CC_OK;
    rsp_data_d  = 16'h0000;
    if (halt) begin
      setup_d = setup_q;
    end else if (hit) begin
      rsp_valid_d = 1'b1;
      if (!data_ok) begin
        rsp_cc_d = `CC_DATA_CHECK;
      end else begin
        unique case (cmd_in.cmd)
          `CMD_PREPARE: begin
            setup_d.level = cmd_in.data[`PREP_LEVEL_LSB +: 4];
            setup_d.allow = cmd_in.data[`PREP_ALLOW_BIT];
          end
          `CMD_STOP: begin
            if (pend_q[cmd_in.sel]) rsp_cc_d = `CC_BUSY;
          end
          `CMD_READ_ID:    rsp_data_d = ID_WORD;
          `CMD_READ_COUNT: rsp_data_d = cnt_q[cmd_in.sel];
          `CMD_READ_MODE:  rsp_data_d = {12'h000, mode_q[cmd_in.sel].src,
                                         mode_q[cmd_in.sel].gate_en};
          default: rsp_cc_d = `CC_OK;
        endcase
      end
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      setup_q   <= '0;
      rsp_valid <= 1'b0;
      rsp_cc    <= `CC_OK;
      rsp_data  <= 16'h0000;
    end else begin
      setup_q   <= setup_d;
      rsp_valid <= rsp_valid_d;
      rsp_cc    <= rsp_cc_d;
      rsp_data  <= rsp_data_d;
    end
  end
  // ************************************************
  // per counter logic
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      logic me, ok;
      logic src_tick;
      always_comb begin
        me = hit && data_ok && (cmd_in.sel == 1'(g));
        ok = me && !halt;
        unique case (mode_q[g].src)
          3'b000:  src_tick = tick[3];
          3'b010:  src_tick = tick[2];
          3'b100:  src_tick = tick[1];
          3'b110:  src_tick = tick[0];
          // rising edge only, so a user clock held high counts once
          default: src_tick = uclk_q[g] & ~uclk_prev_q[g];
        endcase
        cnt_d[g]  = cnt_q[g];
        rld_d[g]  = rld_q[g];
        mode_d[g] = mode_q[g];
        st_d[g]   = st_q[g];
        per_d[g]  = per_q[g];
        pend_d[g] = pend_q[g];
        if (st_q[g] == ST_ARMED && gate_q[g]) st_d[g] = ST_COUNT;
        if (st_q[g] == ST_COUNT && mode_q[g].gate_en && !gate_q[g]) begin
          st_d[g]   = ST_IDLE;
          pend_d[g] = 1'b1;
        end else if (st_q[g] == ST_COUNT && src_tick) begin
          if (cnt_q[g] == 16'h0000) begin
            pend_d[g] = 1'b1;
            cnt_d[g]  = per_q[g] ? rld_q[g] : 16'hffff;
          end else begin
            cnt_d[g] = cnt_q[g] - 16'h0001;
          end
        end
        if (halt) begin
          st_d[g]   = ST_IDLE;
          mode_d[g] = '0;
          pend_d[g] = 1'b0;
        end else if (ok) begin
          unique case (cmd_in.cmd)
            `CMD_LOAD_VAL: begin
              rld_d[g] = cmd_in.data;
              cnt_d[g] = cmd_in.data;
            end
            `CMD_LOAD_MODE: begin
              mode_d[g].src     = cmd_in.data[`MODE_SRC_LSB +: 3];
              mode_d[g].gate_en = cmd_in.data[`MODE_GATE_BIT];
            end
            `CMD_START_PER, `CMD_START_APER: begin
              per_d[g] = (cmd_in.cmd == `CMD_START_PER);
              st_d[g]  = mode_q[g].gate_en ? ST_ARMED : ST_COUNT;
            end
            `CMD_STOP: begin
              if (!pend_q[g]) begin
                st_d[g]   = ST_IDLE;
                pend_d[g] = 1'b0;
              end
            end
            `CMD_DEV_RESET: begin
              st_d[g]   = ST_IDLE;
              mode_d[g] = '0;
              pend_d[g] = 1'b0;
            end
            default: st_d[g] = st_d[g];
          endcase
        end
      end
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          cnt_q[g]   <= 16'h0000;
          rld_q[g]   <= 16'h0000;
          mode_q[g]  <= '0;
          st_q[g]    <= ST_IDLE;
          per_q[g]   <= 1'b0;
          pend_q[g]  <= 1'b0;
          uclk_q[g]  <= 1'b0;
          uclk_prev_q[g] <= 1'b0;
          gate_q[g]  <= 1'b0;
          run[g]     <= 1'b0;
          gate_en[g] <= 1'b0;
          irq_req[g] <= 1'b0;
        end else begin
          cnt_q[g]   <= cnt_d[g];
          rld_q[g]   <= rld_d[g];
          mode_q[g]  <= mode_d[g];
          st_q[g]    <= st_d[g];
          per_q[g]   <= per_d[g];
          pend_q[g]  <= pend_d[g];
          uclk_q[g]  <= user_clk[g];
          uclk_prev_q[g] <= uclk_q[g];
          // gate ignored until enabled
          gate_q[g]  <= user_gate[g] & mode_q[g].gate_en;
          run[g]     <= (st_d[g] != ST_IDLE);
          gate_en[g] <= mode_d[g].gate_en;
          irq_req[g] <= pend_d[g] & setup_d.allow;
        end
      end
    end
  endgenerate
  // ************************************************
  // level outputs, 0 is most urgent
  // ************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_level    <= 4'h0;
      irq_level_oh <= 4'h0;
    end else begin
      irq_level    <= setup_d.level;
      irq_level_oh <= 4'h1 << setup_d.level[1:0];
    end
  end
endmodule : timer_attach
`default_nettype wire

// ---- timer_attach_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module timer_attach_properties
  import timer_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       halt,
  input wire logic [6:0] card_addr,
  input wire logic       cmd_valid,
  input wire cmd_block_t cmd_in,
  input wire logic       data_ok,
  input wire logic [1:0] user_gate,
  input wire logic       rsp_valid,
  input wire logic [2:0] rsp_cc,
  input wire logic [1:0] run,
  input wire logic [1:0] gate_en,
  input wire logic [3:0] irq_level,
  input wire logic [3:0] irq_level_oh
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_ours;
    cmd_valid && cmd_in.card == card_addr && !halt;
  endsequence
  sequence s_cmd(logic [7:0] c);
    s_ours ##0 (data_ok && cmd_in.cmd == c);
  endsequence
  a_answer_next: assert property (s_ours |=> rsp_valid)
    else $error("no answer");
  a_foreign_quiet: assert property (cmd_valid && cmd_in.card != card_addr |=> !rsp_valid)
    else $error("foreign answer");
  a_prepare_not_busy: assert property (s_ours ##0 cmd_in.cmd == `CMD_PREPARE |=> rsp_cc != `CC_BUSY)
    else $error("prepare busy");
  a_data_check: assert property (s_ours ##0 !data_ok |=> rsp_cc == `CC_DATA_CHECK)
    else $error("no data check");
  a_start_runs: assert property (s_cmd(`CMD_START_PER) |=> run[$past(cmd_in.sel)])
    else $error("start no run");
  a_reset_stops: assert property (s_cmd(`CMD_DEV_RESET) |=>
    !run[$past(cmd_in.sel)] && !gate_en[$past(cmd_in.sel)])
    else $error("reset kept run");
  a_gate_en_mode: assert property (s_cmd(`CMD_LOAD_MODE) |=>
    gate_en[$past(cmd_in.sel)] == $past(cmd_in.data[0]))
    else $error("gate enable wrong");
  a_level_onehot: assert property (s_cmd(`CMD_PREPARE) |=>
    irq_level_oh == (4'h1 << $past(cmd_in.data[`PREP_LEVEL_LSB +: 2])))
    else $error("level one-hot wrong");
  a_prepare_level: assert property (s_cmd(`CMD_PREPARE) |=>
    irq_level == $past(cmd_in.data[`PREP_LEVEL_LSB +: 4]))
    else $error("prepare level lost");
  a_gate_drop: assert property (gate_en[1] && run[1] && $fell(user_gate[1]) |->
    ##[1:4] !run[1])
    else $error("gate drop kept run");
endmodule : timer_attach_properties
`default_nettype wire

// ---- user_dev_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module user_dev_model (
  output logic [1:0] user_clk,  // tick lines
  output logic [1:0] user_gate  // gate lines
);
  initial begin
    user_clk = 2'h0;
    user_gate = 2'h0;
  end
  // 1 us period, the fastest legal unfiltered tick
  task automatic pulse(input int ch, input int n);
    repeat (n) begin
      #500 user_clk[ch] = 1'b1;
      #500 user_clk[ch] = 1'b0;
    end
  endtask : pulse
  task automatic gate(input int ch, input logic v);
    user_gate[ch] = v;
  endtask : gate
endmodule : user_dev_model
`default_nettype wire

// ---- timer_attach_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "timer_defs.svh"
module timer_attach_tb;
  import timer_pkg::*;
  localparam logic [6:0]  CARD = 7'h2d;
  localparam logic [15:0] ID   = 16'h1234;  // arbitrary value
  logic core_clk, rst, halt, cmd_valid, data_ok, rsp_valid, got;
  logic [6:0] card_addr;
  cmd_block_t cmd_in;
  logic [1:0] user_clk, user_gate, run, gate_en, irq_req;
  logic [2:0] rsp_cc, cc;
  logic [15:0] rsp_data, rd;
  logic [3:0] irq_level, irq_level_oh;
  int fail_count = 0;
  int samples_checked = 0;
  timer_attach #(.ID_WORD(ID)) timer_attach_i (.core_clk, .rst, .halt, .card_addr,
    .cmd_valid, .cmd_in, .data_ok, .user_clk, .user_gate, .rsp_valid, .rsp_cc,
    .rsp_data, .run, .gate_en, .irq_req, .irq_level, .irq_level_oh);
  user_dev_model user_dev_model_i (.user_clk, .user_gate);
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic op(input logic [7:0] c, input logic s, input logic [15:0] d,
                    input logic [6:0] a = CARD, input logic ok = 1'b1);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_in = '{cmd: c, card: a, sel: s, data: d};
    data_ok = ok;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    data_ok = 1'b1;
    got = rsp_valid;
    cc = rsp_cc;
    rd = rsp_data;
  endtask : op
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : wait_cyc
  task automatic t_ident();
    op(`CMD_READ_ID, 1'b0, 16'h0);
    chk("id", rd, ID);
    op(`CMD_READ_ID, 1'b0, 16'h0, CARD ^ 7'h01);
    chk("foreign", got, 16'h0);
    op(`CMD_LOAD_VAL, 1'b1, 16'h00ab);
    op(`CMD_LOAD_VAL, 1'b1, 16'h0005, CARD, 1'b0);
    chk("dchk cc", cc, 16'h5);
  endtask : t_ident
  task automatic t_periodic();
    op(`CMD_PREPARE, 1'b1, 16'h0005);
    chk("prep cc", cc, 16'h7);
    chk("level", irq_level, 16'h2);
    chk("level oh", irq_level_oh, 16'h4);
    op(`CMD_LOAD_VAL, 1'b0, 16'h0002);
    op(`CMD_LOAD_MODE, 1'b0, 16'h0002);
    op(`CMD_START_PER, 1'b0, 16'h0);
    chk("run0", run[0], 16'h1);
    user_dev_model_i.pulse(0, 2);
    wait_cyc(5);
    chk("early irq", irq_req[0], 16'h0);
    user_dev_model_i.pulse(0, 1);
    wait_cyc(5);
    chk("wrap irq", irq_req[0], 16'h1);
    op(`CMD_READ_COUNT, 1'b0, 16'h0);
    chk("reload", rd, 16'h0002);
    op(`CMD_STOP, 1'b0, 16'h0);
    chk("stop busy", cc, 16'h1);
    op(`CMD_DEV_RESET, 1'b0, 16'h0);
    chk("rst irq", irq_req[0], 16'h0);
    op(`CMD_READ_MODE, 1'b0, 16'h0);
    chk("rst mode", rd, 16'h0);
    op(`CMD_READ_COUNT, 1'b0, 16'h0);
    chk("rst count", rd, 16'h0002);
  endtask : t_periodic
  task automatic t_gate();
    op(`CMD_READ_COUNT, 1'b1, 16'h0);
    chk("count1", rd, 16'h00ab);
    op(`CMD_LOAD_MODE, 1'b1, 16'h0003);
    chk("gate en", gate_en[1], 16'h1);
    op(`CMD_READ_MODE, 1'b1, 16'h0);
    chk("mode1", rd, 16'h0003);
    op(`CMD_START_PER, 1'b1, 16'h0);
    user_dev_model_i.pulse(1, 2);
    op(`CMD_READ_COUNT, 1'b1, 16'h0);
    chk("gated off", rd, 16'h00ab);
    user_dev_model_i.gate(1, 1'b1);
    wait_cyc(3);
    user_dev_model_i.pulse(1, 1);
    user_dev_model_i.gate(1, 1'b0);
    wait_cyc(6);
    chk("drop run", run[1], 16'h0);
    chk("drop irq", irq_req[1], 16'h1);
    op(`CMD_READ_COUNT, 1'b1, 16'h0);
    chk("gated on", rd, 16'h00aa);
    halt = 1'b1;
    wait_cyc(1);
    halt = 1'b0;
    wait_cyc(1);
    chk("halt", {irq_req, gate_en}, 16'h0);
  endtask : t_gate
  task automatic t_internal();
    op(`CMD_LOAD_MODE, 1'b0, 16'h000c);
    op(`CMD_LOAD_VAL, 1'b0, 16'h0005);
    op(`CMD_START_APER, 1'b0, 16'h0);
    wait_cyc(40);
    chk("1us early", irq_req[0], 16'h0);
    wait_cyc(60);
    chk("1us irq", irq_req[0], 16'h1);
  endtask : t_internal
  task automatic rate_check(input logic [15:0] m, input int per);
    op(`CMD_DEV_RESET, 1'b0, 16'h0);
    op(`CMD_LOAD_MODE, 1'b0, m);
    op(`CMD_LOAD_VAL, 1'b0, 16'h0001);
    op(`CMD_START_APER, 1'b0, 16'h0);
    wait_cyc(per - 1);
    chk("rate early", irq_req[0], 16'h0);
    wait_cyc(per + 2);
    chk("rate irq", irq_req[0], 16'h1);
  endtask : rate_check
  task automatic t_slow_rates();
    rate_check(16'h0008, `CYC_5US);
    rate_check(16'h0004, `CYC_25US);
    rate_check(16'h0000, `CYC_50US);
  endtask : t_slow_rates
  task automatic t_quiet();
    op(`CMD_PREPARE, 1'b0, 16'h0006);
    chk("allow off", irq_req[0], 16'h0);
    chk("level3 oh", irq_level_oh, 16'h8);
    op(`CMD_DEV_RESET, 1'b0, 16'h0);
    op(`CMD_START_APER, 1'b0, 16'h0);
    op(`CMD_STOP, 1'b0, 16'h0);
    chk("stop cc", cc, 16'h7);
    chk("stop run", run[0], 16'h0);
  endtask : t_quiet
  task automatic close_out();
    if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (8000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    halt = 1'b0;
    cmd_valid = 1'b0;
    data_ok = 1'b1;
    card_addr = CARD;
    cmd_in = '0;
    wait_cyc(4);
    rst = 1'b0;
    t_ident();
    t_periodic();
    t_gate();
    t_internal();
    t_slow_rates();
    t_quiet();
    close_out();
  end
endmodule : timer_attach_tb
bind timer_attach timer_attach_properties timer_attach_properties_i (.core_clk, .rst,
  .halt, .card_addr, .cmd_valid, .cmd_in, .data_ok, .user_gate, .rsp_valid, .rsp_cc,
  .run, .gate_en, .irq_level, .irq_level_oh);
`default_nettype wire
